// [include/pod_seq_regs.svh]
// Constants for the target access sequencer.
// How it works
// - Only master or slave owns shared RAM.
// - Slave held single-step, advanced by master.
// - Master-loaded sequences stay until slave runs.
// - Slave read value deposited into shared RAM.
// - Test clock runs always; forwarded when enabled.
// - Target buffers enabled only by timing logic.
// - Latch target levels when access concludes.
// - Master reads latches; mismatches flag faults.
// - Timing drives enables, steps, latch triggers.
// - Report power fail outside supply limits.
// - Each step gives RAM to the slave.
// - Only second cycle of access reaches target.
// - Free-run: target buffers on, slave runs.
`ifndef POD_SEQ_REGS_SVH
`define POD_SEQ_REGS_SVH
`define CLK_CFG_ADDR 16'h4000
`define TCLK_DIV 4'h4
`define GAP_CYCLES 2'h1
`define STEP_CYCLES 3'h3
`define LINE_COUNT 8
`define SEL_W 3
`define ZERO8 8'h00
`endif

// [include/pod_seq_pkg.sv]
// Types for the target access sequencer.
package pod_seq_pkg;
  typedef enum {ST_MASTER, ST_GAP_S, ST_SLAVE, ST_CYC2, ST_GAP_M, ST_FREE} seq_state_e;
endpackage

// [design/pod_seq.sv]
// Target access sequencer: shared RAM ownership, slave stepping, target buffers, sense latches.
`timescale 1ns/100ps
`default_nettype none
`include "pod_seq_regs.svh"
module pod_slave_access_sequencer
  import pod_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic step_req,
  input wire logic access_arm,
  input wire logic target_free_run_mode,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic cfg_data,
  input wire logic [7:0] target_level,
  input wire logic [2:0] latch_sel,
  input wire logic [7:0] expect_level,
  input wire logic supply_low,
  input wire logic supply_high,
  output logic master_ram_en,
  output logic slave_ram_en,
  output logic slave_step,
  output logic target_buf_en,
  output logic sense_trigger,
  output logic slave_test_clock,
  output logic slave_test_clock_pin,
  output logic sel_level,
  output logic bus_fault,
  output logic power_fail,
  output logic busy
);
  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  seq_state_e state_reg;
  logic [2:0] cnt_reg;
  logic armed_reg;
  logic [3:0] div_reg;
  logic clk_en_reg;
  logic [7:0] sense_reg;
  logic access_done;

  // Steps pass through a gap state and free-run entry drops the master enable first, so both RAM enables are never high together.
  // A stepped access runs master, gap, slave fetch, then either the target cycle or
  // a fixed number of slave cycles, then a second gap before the master owns RAM again.
  // The outputs below are registered from this state, so each of them shows the state
  // one edge late. That costs a cycle per step, but the buffer enables never glitch.
  // Free run leaves through the master-side gap as well, so the slave enable has
  // dropped before the master enable comes back.
  // A step request is looked at only in the master state. Anything else is refused,
  // which keeps the host from stacking a step on top of a running one.
  // The unarmed step holds the slave for a fixed count, long enough for the
  // slave to fetch and run one instruction from the shared RAM.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_MASTER;
      cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_MASTER: begin
          if (target_free_run_mode) begin
            state_reg <= ST_FREE;
          end else if (step_req) begin
            state_reg <= ST_GAP_S;
            cnt_reg <= 3'h0;
          end
        end
        ST_GAP_S: begin
          state_reg <= ST_SLAVE;
          cnt_reg <= 3'h0;
        end
        ST_SLAVE: begin
          // First cycle of the step is the fetch from shared RAM.
          if (armed_reg) begin
            state_reg <= ST_CYC2;
          end else if (cnt_reg == `STEP_CYCLES) begin
            state_reg <= ST_GAP_M;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        ST_CYC2: begin
          state_reg <= ST_GAP_M;
        end
        ST_GAP_M: begin
          state_reg <= ST_MASTER;
        end
        ST_FREE: begin
          if (!target_free_run_mode) begin
            state_reg <= ST_GAP_M;
          end
        end
        default: begin
          state_reg <= ST_MASTER;
        end
      endcase
    end
  end

  assign access_done = (state_reg == ST_CYC2);

  // Arming lasts one step only, then reverts to standby.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (access_done) begin
      armed_reg <= 1'b0;
    end else if (access_arm && state_reg == ST_MASTER) begin
      armed_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Buffer enables and stepping
  // ------------------------------------------------------------
  // Registered decode keeps every output glitch free.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      master_ram_en <= 1'b1;
      slave_ram_en <= 1'b0;
      slave_step <= 1'b0;
      target_buf_en <= 1'b0;
      sense_trigger <= 1'b0;
      busy <= 1'b0;
    end else begin
      // Master writes sequences and reads results only while it owns RAM.
      master_ram_en <= (state_reg == ST_MASTER) && !target_free_run_mode;
      slave_ram_en <= (state_reg == ST_SLAVE) || (state_reg == ST_FREE);
      slave_step <= (state_reg == ST_GAP_S);
      target_buf_en <= (state_reg == ST_CYC2) || (state_reg == ST_FREE);
      sense_trigger <= access_done;
      busy <= (state_reg != ST_MASTER);
    end
  end

  // ------------------------------------------------------------
  // Test clock
  // ------------------------------------------------------------
  // The divider never stops; only the pin copy is gated.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 4'h0;
      slave_test_clock <= 1'b0;
    end else if (div_reg == `TCLK_DIV) begin
      div_reg <= 4'h0;
      slave_test_clock <= ~slave_test_clock;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en_reg <= 1'b0;
    end else if (cfg_wr && cfg_addr == `CLK_CFG_ADDR) begin
      clk_en_reg <= cfg_data;
    end
  end

  // The pin is a registered copy of the running clock, held low until enabled.
  // It lags the internal clock by one cycle; the target only sees the same shape.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slave_test_clock_pin <= 1'b0;
    end else begin
      slave_test_clock_pin <= clk_en_reg & slave_test_clock;
    end
  end

  // ------------------------------------------------------------
  // Sense latches and fault compare
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `LINE_COUNT; gi++) begin : g_sense
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          sense_reg[gi] <= 1'b0;
        end else if (sense_trigger) begin
          // Capture at the end of the target window, when the access concludes.
          // Capturing as the buffers open would store a level still settling.
          sense_reg[gi] <= target_level[gi];
        end
      end
    end
  endgenerate

  // Addressed read of one latch; fault when any line differs from expectation.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_level <= 1'b0;
      bus_fault <= 1'b0;
      power_fail <= 1'b0;
    end else begin
      sel_level <= sense_reg[latch_sel];
      bus_fault <= (sense_reg != expect_level);
      power_fail <= supply_low || supply_high;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence step_fetch_s;
    state_reg == ST_GAP_S ##1 state_reg == ST_SLAVE;
  endsequence

  ram_exclusive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(master_ram_en && slave_ram_en)) else $error("RAM enables overlap.");
  step_owner_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    step_fetch_s |=> slave_ram_en) else $error("Slave lacks RAM on step.");
  step_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    slave_step |=> !slave_step) else $error("Step longer than one cycle.");
  target_iso_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    target_buf_en && state_reg != ST_FREE |=> !target_buf_en)
    else $error("Target buffer held past access.");
  latch_capture_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sense_trigger |=> sense_reg == $past(target_level)) else $error("Latch missed level.");
  trigger_time_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    access_done |=> sense_trigger) else $error("No latch trigger.");
  arm_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    access_done |=> !armed_reg) else $error("Arming not cleared.");
  free_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_FREE |=> target_buf_en && slave_ram_en) else $error("Free run off.");
  power_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    supply_low |=> power_fail) else $error("Power fail missed.");
  clock_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    div_reg == `TCLK_DIV |=> slave_test_clock != $past(slave_test_clock))
    else $error("Test clock stalled.");
  handover_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(master_ram_en) |-> !slave_ram_en) else $error("No break before make.");
  fault_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sense_reg != expect_level |=> bus_fault) else $error("Fault not flagged.");

  // ------------------------------------------------------------
  // Checks on the armed access, the clock pin, refusals, latches, power, free run and handback
  // ------------------------------------------------------------
  // The slave is in its fetch cycle with a target access pending.
  sequence armed_fetch_s;
    state_reg == ST_SLAVE && armed_reg;
  endsequence

  // Buffers and latch trigger open together for one cycle, then both close.
  sequence target_window_s;
    target_buf_en && sense_trigger ##1 !target_buf_en && !sense_trigger;
  endsequence

  armed_access_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    armed_fetch_s |-> ##2 target_window_s) else $error("Target window malformed.");

  // A step request while busy must not raise a step pulse.
  step_refused_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    busy && step_req |=> !slave_step) else $error("Step taken while busy.");

  // Arming outside the master state is refused.
  arm_refused_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    access_arm && state_reg != ST_MASTER && !armed_reg |=> !armed_reg)
    else $error("Arming taken while busy.");

  // The pin stays low until the configuration write enables it.
  pin_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en_reg |=> !slave_test_clock_pin) else $error("Clock pin not gated.");

  // Once enabled, the pin follows the running clock.
  pin_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en_reg |=> slave_test_clock_pin == $past(slave_test_clock))
    else $error("Clock pin not following.");

  // Latches keep their value between triggers.
  sense_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !sense_trigger |=> sense_reg == $past(sense_reg)) else $error("Latch drifted.");

  // The addressed latch reaches the read port one edge later.
  sel_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> sel_level == $past(sense_reg[latch_sel])) else $error("Latch read wrong.");

  power_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    supply_high |=> power_fail) else $error("High supply missed.");

  power_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !supply_low && !supply_high |=> !power_fail) else $error("Power fail stuck.");

  // Entering free run takes the RAM from the master at once.
  free_entry_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    target_free_run_mode && state_reg == ST_MASTER |=> !master_ram_en)
    else $error("Master kept RAM in free run.");

  // The master gets the RAM back only after the slave and target sides closed.
  handback_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(master_ram_en) |-> !slave_ram_en && !target_buf_en)
    else $error("Handback overlaps.");

  // Counts stepped cycles of slave ownership; a stuck step would starve the master.
  logic [2:0] own_cnt_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      own_cnt_reg <= 3'h0;
    end else if (slave_ram_en && state_reg != ST_FREE) begin
      own_cnt_reg <= own_cnt_reg + 3'h1;
    end else begin
      own_cnt_reg <= 3'h0;
    end
  end

  step_bound_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    own_cnt_reg <= `STEP_CYCLES + 3'h1) else $error("Slave held RAM too long.");
endmodule
`default_nettype wire

// [verif/target_bus_model.sv]
// Target board bus model that presents levels on the eight sensed lines.
`timescale 1ns/100ps
`default_nettype none
module target_bus_model (
  input wire logic [7:0] level_set,
  output logic [7:0] target_level
);
  // The bus always shows a driven level, so the sense latches see something real.
  assign target_level = level_set;
endmodule
`default_nettype wire

// [verif/pod_seq_tb.sv]
// Self-checking testbench for the target access sequencer.
`timescale 1ns/100ps
`default_nettype none
module pod_slave_access_sequencer_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic step_req = 1'b0;
  logic access_arm = 1'b0;
  logic free_run = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_data = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0] lvl = 8'h00;
  logic [2:0] latch_sel = 3'h0;
  logic [7:0] expect_level = 8'h00;
  logic supply_low = 1'b0;
  logic supply_high = 1'b0;
  logic [7:0] target_level;
  logic master_ram_en, slave_ram_en, slave_step, target_buf_en, sense_trigger;
  logic slave_test_clock, slave_test_clock_pin, sel_level, bus_fault, power_fail, busy;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  wire [5:0] obs = {master_ram_en, slave_ram_en, slave_step, target_buf_en, sense_trigger, busy};
  // ----------------------------------------
  // Clock, instances and watchdog
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  target_bus_model bus (.level_set(lvl), .target_level(target_level));
  pod_slave_access_sequencer dut (.ref_clk(ref_clk), .resetn(resetn), .step_req(step_req),
    .access_arm(access_arm), .target_free_run_mode(free_run), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .target_level(target_level),
    .latch_sel(latch_sel), .expect_level(expect_level), .supply_low(supply_low),
    .supply_high(supply_high), .master_ram_en(master_ram_en), .slave_ram_en(slave_ram_en),
    .slave_step(slave_step), .target_buf_en(target_buf_en), .sense_trigger(sense_trigger),
    .slave_test_clock(slave_test_clock), .slave_test_clock_pin(slave_test_clock_pin),
    .sel_level(sel_level), .bus_fault(bus_fault), .power_fail(power_fail), .busy(busy));
  // A hang would otherwise stall the run forever; the tests need well under 2000 cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // Both RAM buffers on at once would corrupt the shared RAM, so watch every cycle.
  always @(negedge ref_clk) begin
    if (resetn) chk(master_ram_en & slave_ram_en, 8'h00);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic step_walk(input logic armed);
    logic [5:0] exp [6];
    if (armed) exp = '{6'b001001, 6'b010001, 6'b000111, 6'b000001, 6'b100000, 6'b100000};
    else exp = '{6'b001001, 6'b010001, 6'b010001, 6'b010001, 6'b010001, 6'b000001};
    access_arm = armed;
    step_req = 1'b1;
    @(negedge ref_clk);
    step_req = 1'b0;
    access_arm = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      chk(obs, exp[i]);
    end
    for (int i = 0; i < 10 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk({master_ram_en, slave_ram_en, busy}, 8'h04);
    $display("step test done armed=%0d", armed);
  endtask
  task automatic sense_test();
    lvl = 8'ha5;
    step_walk(1'b1);
    lvl = 8'h00;
    for (int i = 0; i < 8; i++) begin
      latch_sel = 3'(i);
      repeat (2) @(negedge ref_clk);
      chk(sel_level, 8'(lvl[i] ^ ((8'ha5 >> i) & 8'h01)));
    end
    expect_level = 8'ha5;
    repeat (2) @(negedge ref_clk);
    chk(bus_fault, 8'h00);
    expect_level = 8'ha4;
    repeat (2) @(negedge ref_clk);
    chk(bus_fault, 8'h01);
    $display("sense test done");
  endtask
  task automatic clock_test();
    int t_clk = 0;
    int t_pin = 0;
    logic prev_clk;
    logic prev_pin;
    prev_clk = slave_test_clock;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if (slave_test_clock !== prev_clk) t_clk++;
      prev_clk = slave_test_clock;
      if (slave_test_clock_pin !== 1'b0) t_pin++;
    end
    chk(8'(t_clk), 8'h04);
    chk(8'(t_pin), 8'h00);
    cfg_addr = 16'h4000;
    cfg_data = 1'b1;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_pin = 0;
    prev_pin = slave_test_clock_pin;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if (slave_test_clock_pin !== prev_pin) t_pin++;
      prev_pin = slave_test_clock_pin;
    end
    chk(8'(t_pin), 8'h04);
    $display("clock test done");
  endtask
  task automatic mode_power_test();
    free_run = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(target_buf_en, 8'h01);
    free_run = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(target_buf_en, 8'h00);
    supply_low = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(power_fail, 8'h01);
    supply_low = 1'b0;
    supply_high = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(power_fail, 8'h01);
    supply_high = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(power_fail, 8'h00);
    $display("mode and power test done");
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    chk(obs, 8'h20);
    resetn = 1'b1;
    step_walk(1'b0);
    step_walk(1'b0);
    sense_test();
    clock_test();
    mode_power_test();
    stop_test();
  end
endmodule
`default_nettype wire
